// [logic/spd_ctrl.sv]
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module spd_ctrl
#(
    parameter int STEP_PERIOD_CYC = spd_pkg::SPD_STEP_CYC
)
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // bridge driver pins
    output logic             ch1_direction_in,
    output logic             ch1_output_gate,
    output logic             ch2_direction_in,
    output logic             ch2_output_gate,
    output logic             standby_select
);

    // bus pipeline state
    logic        wr_q;
    logic [7:0]  ad_q;
    logic [31:0] rdata_q;

    // software registers
    logic [4:0]  ctrl_q;
    logic [31:0] period_q;
    logic [31:0] steps_q;
    logic [31:0] steps_d;
    logic [31:0] pos_q;
    logic [31:0] pos_d;

    // sequencer state
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [2:0]  idx_q;
    logic [2:0]  idx_nx;
    logic [3:0]  pins_q;
    logic [3:0]  pins_d;

    // address phase decode; whole-word accesses only, so hsize is not decoded
    wire        acc_w     = hsel & hready & htrans[1];
    wire [7:0]  a_w       = haddr[7:0];
    wire        wr_ctrl   = wr_q & (ad_q == spd_pkg::SPD_CTRL_OFF);
    wire        wr_period = wr_q & (ad_q == spd_pkg::SPD_PERIOD_OFF);
    wire        wr_steps  = wr_q & (ad_q == spd_pkg::SPD_STEPS_OFF);
    wire        wr_pos    = wr_q & (ad_q == spd_pkg::SPD_POS_OFF);

    // control fields
    wire        run_w   = ctrl_q[spd_pkg::SPD_RUN_BIT];
    wire        dir_w   = ctrl_q[spd_pkg::SPD_DIR_BIT];
    wire        half_w  = ctrl_q[spd_pkg::SPD_HALF_BIT];
    wire        awake_w = ctrl_q[spd_pkg::SPD_AWAKE_BIT];
    wire        cont_w  = ctrl_q[spd_pkg::SPD_CONT_BIT];

    // stepping is only allowed while the bridge is awake
    wire        busy_w  = run_w & awake_w & (cont_w | (steps_q != 32'h0000_0000));
    wire [31:0] per_m1  = (period_q == 32'h0000_0000) ? 32'h0000_0000
                                                      : period_q - 32'h0000_0001;
    wire        step_go = busy_w & (cnt_q == per_m1);

    // status word: pins, index, awake, busy
    wire [31:0] status_w = {20'h00000, pins_q, 1'b0, idx_q, 2'b00, awake_w, busy_w};

    // read mux, sampled in the address phase
    wire [31:0] rmux_w =
        (a_w == spd_pkg::SPD_CTRL_OFF)   ? {27'h0000000, ctrl_q} :
        (a_w == spd_pkg::SPD_PERIOD_OFF) ? period_q :
        (a_w == spd_pkg::SPD_STEPS_OFF)  ? steps_q :
        (a_w == spd_pkg::SPD_STATUS_OFF) ? status_w :
        (a_w == spd_pkg::SPD_POS_OFF)    ? pos_q :
                                           32'h0000_0000;

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // address phase capture; unmapped reads return zero, writes drop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q    <= 1'b0;
            ad_q    <= 8'h00;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wr_q <= acc_w & hwrite;
            if (acc_w)
            begin
                ad_q <= a_w;
            end
            if (acc_w & ~hwrite)
            begin
                rdata_q <= rmux_w;
            end
        end
    end

    // control and period registers written in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q   <= spd_pkg::SPD_CTRL_RST;
            period_q <= 32'(STEP_PERIOD_CYC);
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl_q <= hwdata[spd_pkg::SPD_CTRL_W-1:0];
            end
            if (wr_period)
            begin
                period_q <= hwdata;
            end
        end
    end

    // step timer restarts whenever stepping is halted
    assign cnt_d = !busy_w ? 32'h0000_0000 :
                   step_go ? 32'h0000_0000 : cnt_q + 32'h0000_0001;

    // a fresh count written by software wins over the step in flight
    assign steps_d = wr_steps                       ? hwdata :
                     (step_go & ~cont_w)            ? steps_q - 32'h0000_0001 :
                                                      steps_q;

    // position: up clockwise, down counterclockwise
    assign pos_d = wr_pos             ? hwdata :
                   (step_go & dir_w)  ? pos_q - 32'h0000_0001 :
                   step_go            ? pos_q + 32'h0000_0001 :
                                        pos_q;

    // wrap after the last step of the selected table
    assign idx_nx = half_w ? idx_q + 3'd1 : {1'b0, idx_q[1:0] + 2'd1};

    // each direction has its own table; full mode keeps both gates at 0
    assign pins_d = !step_go       ? pins_q :
                    (half_w &  dir_w) ? spd_pkg::SPD_HALF_CCW[idx_nx] :
                    (half_w & ~dir_w) ? spd_pkg::SPD_HALF_CW[idx_nx] :
                    dir_w             ? spd_pkg::SPD_FULL_CCW[idx_nx[1:0]] :
                                        spd_pkg::SPD_FULL_CW[idx_nx[1:0]];

    // sequencer registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q   <= 32'h0000_0000;
            steps_q <= spd_pkg::SPD_STEPS_RST;
            pos_q   <= spd_pkg::SPD_POS_RST;
            idx_q   <= 3'd0;
            pins_q  <= spd_pkg::SPD_PINS_RST;
        end
        else
        begin
            cnt_q   <= cnt_d;
            steps_q <= steps_d;
            pos_q   <= pos_d;
            pins_q  <= pins_d;
            if (step_go)
            begin
                idx_q <= idx_nx;
            end
        end
    end

    // standby follows the awake bit; pins keep their last pattern meanwhile
    logic stby_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stby_q <= 1'b0;
        end
        else
        begin
            stby_q <= awake_w;
        end
    end

    // pin drive; gate at 1 turns the channel off on the bridge side
    assign ch1_direction_in = pins_q[3];
    assign ch1_output_gate  = pins_q[2];
    assign ch2_direction_in = pins_q[1];
    assign ch2_output_gate  = pins_q[0];
    assign standby_select   = stby_q;

    // checks on the sequencer
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_full_cw0;
        step_go && !half_w && !dir_w && (idx_q[1:0] == 2'd0);
    endsequence

    sequence s_full_ccw0;
        step_go && !half_w && dir_w && (idx_q[1:0] == 2'd0);
    endsequence

    sequence s_last_step;
        step_go && !cont_w && !wr_steps && (steps_q == 32'h0000_0001);
    endsequence

    sequence s_stopped;
        (steps_q == 32'h0000_0000) ##1 !step_go;
    endsequence

    property p_full_cw;
        s_full_cw0 |=> (pins_q == 4'h8);
    endproperty
    a_full_cw: assert property (p_full_cw)
        else $error("clockwise 2-phase step 1 pattern wrong");

    property p_full_gate;
        (step_go && !half_w) |=> (!ch1_output_gate && !ch2_output_gate);
    endproperty
    a_full_gate: assert property (p_full_gate)
        else $error("gate driven high in 2-phase mode");

    property p_full_ccw;
        s_full_ccw0 |=> (pins_q == 4'hA) && (idx_q == 3'd1);
    endproperty
    a_full_ccw: assert property (p_full_ccw)
        else $error("counterclockwise 2-phase step 1 pattern wrong");

    property p_half_cw;
        (step_go && half_w && !dir_w && (idx_q == 3'd3)) |=> (pins_q == 4'hB);
    endproperty
    a_half_cw: assert property (p_half_cw)
        else $error("clockwise 1-2 phase step 4 pattern wrong");

    property p_half_ccw;
        (step_go && half_w && dir_w && (idx_q == 3'd5)) |=> (pins_q == 4'h4);
    endproperty
    a_half_ccw: assert property (p_half_ccw)
        else $error("counterclockwise 1-2 phase step 6 pattern wrong");

    property p_wrap;
        (step_go && ((half_w && idx_q == 3'd7) || (!half_w && idx_q[1:0] == 2'd3)))
            |=> (idx_q == 3'd0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("sequence did not wrap to step 0");

    property p_hold;
        !step_go |=> $stable(pins_q) && $stable(idx_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pins moved without a step");

    property p_sleep;
        (wr_ctrl && !hwdata[spd_pkg::SPD_AWAKE_BIT])
            |=> !busy_w ##1 (!standby_select && !step_go);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("standby not driven after sleep write");

    property p_count;
        s_last_step |=> s_stopped;
    endproperty
    a_count: assert property (p_count)
        else $error("stepping went on past the requested count");

    // wrap-around of the tables that do not start at pattern 0
    property p_full_ccw_wrap;
        (step_go && !half_w && dir_w && (idx_q[1:0] == 2'd3)) |=> (pins_q == 4'h2);
    endproperty
    a_full_ccw_wrap: assert property (p_full_ccw_wrap)
        else $error("counterclockwise 2-phase wrap to step 0 wrong");

    property p_half_cw_wrap;
        (step_go && half_w && !dir_w && (idx_q == 3'd7)) |=> (pins_q == 4'h1);
    endproperty
    a_half_cw_wrap: assert property (p_half_cw_wrap)
        else $error("clockwise 1-2 phase wrap to step 0 wrong");

    property p_half_ccw_wrap;
        (step_go && half_w && dir_w && (idx_q == 3'd7)) |=> (pins_q == 4'h3);
    endproperty
    a_half_ccw_wrap: assert property (p_half_ccw_wrap)
        else $error("counterclockwise 1-2 phase wrap to step 0 wrong");

    // no table ever gates both channels off at once
    property p_one_gate;
        !(ch1_output_gate && ch2_output_gate);
    endproperty
    a_one_gate: assert property (p_one_gate)
        else $error("both channel gates driven high");

    // software position must track every step not overridden by a position write, one count per step
    property p_pos_step;
        (step_go && !wr_pos)
            |=> (pos_q == $past(pos_q) + ($past(dir_w) ? 32'hFFFF_FFFF : 32'h0000_0001));
    endproperty
    a_pos_step: assert property (p_pos_step)
        else $error("position did not follow the step direction");

endmodule

// [include/spd_pkg.sv]
package spd_pkg;

    // register byte offsets
    localparam logic [7:0] SPD_CTRL_OFF   = 8'h00;
    localparam logic [7:0] SPD_PERIOD_OFF = 8'h04;
    localparam logic [7:0] SPD_STEPS_OFF  = 8'h08;
    localparam logic [7:0] SPD_STATUS_OFF = 8'h0C;
    localparam logic [7:0] SPD_POS_OFF    = 8'h10;

    // control fields and reset value
    localparam int          SPD_RUN_BIT   = 0;
    localparam int          SPD_DIR_BIT   = 1;
    localparam int          SPD_HALF_BIT  = 2;
    localparam int          SPD_AWAKE_BIT = 3;
    localparam int          SPD_CONT_BIT  = 4;
    localparam int          SPD_CTRL_W    = 5;
    localparam logic [4:0]  SPD_CTRL_RST  = 5'h00;
    localparam logic [31:0] SPD_STEPS_RST = 32'h0000_0000;
    localparam logic [31:0] SPD_POS_RST   = 32'h0000_0000;
    localparam logic [3:0]  SPD_PINS_RST  = 4'h0;

    // step timing: time in us, count derived from the clock rate
    localparam int SPD_CLK_MHZ      = 125;
    localparam int SPD_STEP_TIME_US = 1000;
    localparam int SPD_STEP_CYC     = SPD_STEP_TIME_US * SPD_CLK_MHZ;

    // pin patterns {ch1 phase, ch1 gate, ch2 phase, ch2 gate}
    localparam logic [3:0] SPD_FULL_CW  [0:3] = '{4'h0, 4'h8, 4'hA, 4'h2};
    localparam logic [3:0] SPD_FULL_CCW [0:3] = '{4'h2, 4'hA, 4'h8, 4'h0};
    localparam logic [3:0] SPD_HALF_CW  [0:7] =
        '{4'h1, 4'h0, 4'hC, 4'h8, 4'hB, 4'hA, 4'h6, 4'h2};
    localparam logic [3:0] SPD_HALF_CCW [0:7] =
        '{4'h3, 4'h2, 4'hE, 4'hA, 4'h9, 4'h8, 4'h4, 4'h0};

endpackage

// [verif/spd_bridge_model.sv]
`timescale 1ns/1ps
// bridge decoder model; an off output is shown as both drives low
module spd_bridge_model
(
    // logic inputs from the controller
    input  wire logic ch1_direction_in,
    input  wire logic ch1_output_gate,
    input  wire logic ch2_direction_in,
    input  wire logic ch2_output_gate,
    input  wire logic standby_select,
    // bridge drives and supply state
    output logic      ch1_pos_drive,
    output logic      ch1_neg_drive,
    output logic      ch2_pos_drive,
    output logic      ch2_neg_drive,
    output logic      low_drain
);
    // a channel conducts only while awake with its gate at 0
    wire logic ch1_on = standby_select & ~ch1_output_gate;
    wire logic ch2_on = standby_select & ~ch2_output_gate;
    // each channel looks at its own pins and the shared standby pin only
    assign ch1_pos_drive = ch1_on & ch1_direction_in;
    assign ch1_neg_drive = ch1_on & ~ch1_direction_in;
    assign ch2_pos_drive = ch2_on & ch2_direction_in;
    assign ch2_neg_drive = ch2_on & ~ch2_direction_in;
    // supply drain drops to a trickle in standby
    assign low_drain = ~standby_select;
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
    // bus, pins and bridge nets
    logic             hclk    = 1'b0;
    logic             hresetn = 1'b0;
    logic             hsel    = 1'b0;
    logic             hwrite  = 1'b0;
    logic [1:0]       htrans  = 2'h0;
    logic [2:0]       hsize   = 3'h0;
    logic [31:0]      haddr   = 32'h0;
    logic [31:0]      hwdata  = 32'h0;
    logic [31:0]      rd;
    wire logic        hreadyout, hresp, p1, g1, p2, g2, stby;
    wire logic [31:0] hrdata;
    wire logic        d1p, d1n, d2p, d2n, low_drain;
    wire logic [3:0]  pins = {p1, g1, p2, g2};
    wire logic [3:0]  drv  = {d1p, d1n, d2p, d2n};
    int               fails      = 0;
    int               n_compared = 0;
    // short step period keeps the run small
    localparam int    STEP_CYC   = 4;
    // one row: control word, eight pin patterns and eight bridge drives from step 0
    typedef struct { logic [31:0] ctrl; logic [31:0] pat; logic [31:0] drv; } spd_row_t;
    spd_row_t rows [4] = '{
        '{32'h19, 32'h08A2_08A2, 32'h59A6_59A6},
        '{32'h1B, 32'h2A80_2A80, 32'h6A95_6A95},
        '{32'h1D, 32'h10C8_BA62, 32'h4519_8A26},
        '{32'h1F, 32'h32EA_9840, 32'h462A_8915}};

    always #4 hclk = ~hclk;

    spd_ctrl #(.STEP_PERIOD_CYC(STEP_CYC)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ch1_direction_in(p1), .ch1_output_gate(g1), .ch2_direction_in(p2),
        .ch2_output_gate(g2), .standby_select(stby));
    spd_bridge_model bridge (.ch1_direction_in(p1), .ch1_output_gate(g1),
        .ch2_direction_in(p2), .ch2_output_gate(g2), .standby_select(stby),
        .ch1_pos_drive(d1p), .ch1_neg_drive(d1n), .ch2_pos_drive(d2p),
        .ch2_neg_drive(d2n), .low_drain(low_drain));

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // a wait that runs out ends the run at once
    task automatic give_up();
        fails++;
        tally_and_finish();
    endtask

    // single word transfer; hold each phase until hready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        haddr  <= {24'h0, a};
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 40);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 80);
        if (k >= 40)
            give_up();
        rd = hrdata;
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    // one step period on, then look mid-cycle where the pins have settled;
    // timed, not change-driven, since a step may repeat the reset pattern
    task automatic step_wait(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask

    initial
    begin
        do_reset();
        // reset values, offset 0x14 is unmapped
        for (int i = 0; i < 6; i++)
        begin
            xfer(1'b0, 8'(4 * i), 32'h0);
            `CHK("reset reg", (i == 1) ? 32'h4 : 32'h0, rd)
            `CHK("resp", 1'b0, hresp)
        end
        `CHK("reset pins", 5'h00, {stby, pins})
        `CHK("asleep drv", 4'h0, drv)
        `CHK("drain", 1'b1, low_drain)
        // every mode, eight steps so the last one wraps to step 0
        foreach (rows[r])
        begin
            do_reset();
            xfer(1'b1, 8'h00, rows[r].ctrl);
            for (int s = 1; s <= 8; s++)
            begin
                logic [3:0] ep;
                logic [3:0] ed;
                ep = rows[r].pat[31 - 4 * (s % 8) -: 4];
                ed = rows[r].drv[31 - 4 * (s % 8) -: 4];
                step_wait(STEP_CYC);
                `CHK("pins", ep, pins)
                `CHK("drv", ed, drv)
            end
            @(posedge hclk);
            xfer(1'b0, 8'h10, 32'h0);
            `CHK("position", rows[r].ctrl[1] ? 32'hFFFF_FFF8 : 32'h8, rd)
            `CHK("awake drain", 1'b0, low_drain)
        end
        // counted run of two steps, junk in the upper control bits
        do_reset();
        xfer(1'b1, 8'h04, 32'h2);
        xfer(1'b1, 8'h08, 32'h2);
        xfer(1'b1, 8'h00, 32'hFFFF_FFE9);
        step_wait(2);
        `CHK("first", 4'h8, pins)
        step_wait(2);
        `CHK("second", 4'hA, pins)
        repeat (20) @(posedge hclk);
        `CHK("held", 4'hA, pins)
        xfer(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h9, rd)
        xfer(1'b0, 8'h0C, 32'h0);
        `CHK("status", 32'h0000_0A22, rd)
        // period 0 acts as 1; a loaded position counts on from the written value
        xfer(1'b1, 8'h04, 32'h0);
        xfer(1'b1, 8'h10, 32'h0000_0100);
        xfer(1'b1, 8'h08, 32'h1);
        step_wait(1);
        `CHK("fast step", 4'h2, pins)
        @(posedge hclk);
        xfer(1'b0, 8'h10, 32'h0);
        `CHK("loaded position", 32'h0000_0101, rd)
        // asleep: bridge off, no steps even with steps loaded
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b1, 8'h08, 32'h1);
        repeat (20) @(posedge hclk);
        `CHK("standby", 5'h02, {stby, pins})
        `CHK("asleep drv", 4'h0, drv)
        `CHK("drain", 1'b1, low_drain)
        tally_and_finish();
    end
endmodule
